/* rtl/ddrfl_lane.sv */
// Write-leveling feedback for one byte lane
`timescale 1ns/1ps
`default_nettype none
module ddrfl_lane
  import ddrfl_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Leveling inputs
  input wire logic lvl_on,
  input wire logic strobe,
  input wire logic ck_level,
  // Data pins of the lane
  output logic [7:0] dq_q,
  output logic dq_oe_q
);
  logic strobe_q, strobe_d;
  logic [7:0] dq_d;
  logic dq_oe_d;

  // Next feedback value
  always_comb begin
    strobe_d = strobe;
    dq_d = dq_q;
    dq_oe_d = lvl_on;
    if (!lvl_on) begin
      dq_d = 8'h00;
    end else if (strobe && !strobe_q) begin
      dq_d = {8{ck_level}};
    end
  end

  // Feedback registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      strobe_q <= 1'b0;
      dq_q <= 8'h00;
      dq_oe_q <= 1'b0;
    end else begin
      strobe_q <= strobe_d;
      dq_q <= dq_d;
      dq_oe_q <= dq_oe_d;
    end
  end
endmodule
`default_nettype wire

/* rtl/ddrfl_pkg.sv */
// Constants, types and register map for the DDR3 clock-change and write-leveling block
package ddrfl_pkg;
  // Register byte offsets
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [3:0] REG_MR0 = 4'h8;
  localparam logic [3:0] REG_MR1 = 4'hc;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0001;
  // Control and status field positions
  localparam int CTRL_CHECK_BIT = 0;
  localparam int ST_LVL_BIT = 3;
  localparam int ST_LOCK_BIT = 4;
  localparam int ERR_FREQ_BIT = 8;
  localparam int ERR_LVLCMD_BIT = 9;
  localparam int ERR_RELOCK_BIT = 10;
  // Mode register fields
  localparam int MR0_DLL_RESET_BIT = 8;
  localparam int MR1_LVL_BIT = 7;
  localparam int MR1_QOFF_BIT = 12;
  localparam int MR1_RTT0_BIT = 2;
  localparam int MR1_RTT1_BIT = 6;
  localparam int MR1_RTT2_BIT = 9;
  localparam logic [15:0] MR_RESET = 16'h0000;
  // DLL lock time in clock cycles
  localparam logic [9:0] TDLLK_NCK = 10'h200;
  // Command codes on the command pins
  localparam logic [2:0] CMD_NOP = 3'h0;
  localparam logic [2:0] CMD_DES = 3'h1;
  localparam logic [2:0] CMD_MRS = 3'h2;
  localparam logic [2:0] CMD_SRE = 3'h3;
  localparam logic [2:0] CMD_SRX = 3'h4;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;
  typedef enum logic [2:0] {ST_IDLE, ST_PDN, ST_SREF, ST_RELOCK} ddrfl_state_t;
endpackage

/* rtl/ddrfl_top.sv */
// DRAM-side clock change, DLL relock and write-leveling logic with AXI4-Lite registers
`timescale 1ns/1ps
`default_nettype none
module ddrfl_top
  import ddrfl_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address and data
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Memory command pins
  input wire logic cke,
  input wire logic odt,
  input wire logic cmd_valid,
  input wire logic [2:0] cmd_code,
  input wire logic [2:0] cmd_bank,
  input wire logic [15:0] cmd_addr,
  input wire logic clk_step,
  input wire logic ck_level,
  // Strobe pairs, sampled level
  input wire logic lower_strobe_pair,
  input wire logic upper_strobe_pair,
  // Data pins
  output logic [15:0] dq_o,
  output logic [15:0] dq_oe,
  // Termination and readiness
  output logic strobe_term_q,
  output logic dq_term_q,
  output logic dll_locked_q
);
  ddrfl_state_t st_q, st_d;
  logic [15:0] mr0_q, mr0_d, mr1_q, mr1_d;
  logic [9:0] cnt_q, cnt_d;
  logic [2:0] err_q, err_d;
  logic [31:0] ctrl_q, ctrl_d;
  logic strobe_term_d, dq_term_d, dll_locked_d;
  logic aw_have_q, aw_have_d, w_have_q, w_have_d;
  logic [3:0] awaddr_q, awaddr_d;
  logic [31:0] wdata_q, wdata_d;
  logic [3:0] wstrb_q, wstrb_d;
  logic awready_d, wready_d, bvalid_d, arready_d, rvalid_d;
  logic [1:0] bresp_d, rresp_d;
  logic [31:0] rdata_d;
  logic lvl_on, rtt_nom_on, chk, is_mrs, wr_go, err_clr_wr;
  logic [2:0] err_set, err_clr;
  logic [31:0] status_w;
  logic oe_lo, oe_hi;

  // Decoded mode and helper terms
  assign lvl_on = mr1_q[MR1_LVL_BIT];
  assign rtt_nom_on = mr1_q[MR1_RTT0_BIT] | mr1_q[MR1_RTT1_BIT] | mr1_q[MR1_RTT2_BIT];
  assign chk = ctrl_q[CTRL_CHECK_BIT];
  assign is_mrs = cmd_valid && cmd_code == CMD_MRS;
  assign wr_go = aw_have_q && w_have_q && !s_axi_bvalid;
  assign err_clr_wr = wr_go && awaddr_q == REG_STATUS && wstrb_q[1];
  assign status_w = {21'h0, err_q, 3'h0, dll_locked_q, lvl_on, st_q};

  // Device state, mode registers and protocol checks
  always_comb begin
    st_d = st_q;
    mr0_d = mr0_q;
    mr1_d = mr1_q;
    cnt_d = cnt_q;
    dll_locked_d = dll_locked_q;
    err_set = 3'h0;
    case (st_q)
      ST_IDLE: begin
        if (cmd_valid && cmd_code == CMD_SRE) begin
          st_d = ST_SREF;
        end else if (!cke) begin
          st_d = ST_PDN;
        end
      end
      ST_PDN: begin
        if (cke) begin
          st_d = ST_IDLE;
        end
      end
      ST_SREF: begin
        if (cmd_valid && cmd_code == CMD_SRX && cke) begin
          st_d = ST_IDLE;
        end
      end
      ST_RELOCK: begin
        cnt_d = cnt_q - 10'h001;
        if (cnt_q == 10'h001) begin
          st_d = ST_IDLE;
          dll_locked_d = 1'b1;
        end
        if (odt || !cke) begin
          err_set[2] = 1'b1;
        end
      end
      default: st_d = ST_IDLE;
    endcase
    // DLL reset via mode register 0
    if (is_mrs && cmd_bank == 3'h0) begin
      mr0_d = cmd_addr;
      if (cmd_addr[MR0_DLL_RESET_BIT] && st_q != ST_SREF && st_q != ST_PDN) begin
        st_d = ST_RELOCK;
        cnt_d = TDLLK_NCK;
        dll_locked_d = 1'b0;
      end
    end
    if (is_mrs && cmd_bank == 3'h1) begin
      mr1_d = cmd_addr;
    end
    // clock change only in low-power states
    if (clk_step && st_q != ST_SREF && st_q != ST_PDN) begin
      err_set[0] = 1'b1;
    end
    // CKE low, and ODT low when rtt_nom_on, in power-down change
    if (clk_step && st_q == ST_PDN && (cke || (odt && rtt_nom_on))) begin
      err_set[0] = 1'b1;
    end
    if (st_q == ST_SREF || st_q == ST_PDN) begin
      dll_locked_d = dll_locked_q && !clk_step;
    end
    // only NOP, Deselect or MR1 update
    if (lvl_on && cmd_valid && cmd_code != CMD_NOP && cmd_code != CMD_DES
        && !(is_mrs && cmd_bank == 3'h1)) begin
      err_set[1] = 1'b1;
    end
    err_set = chk ? err_set : 3'h0;
    err_clr = err_clr_wr ? wdata_q[ERR_RELOCK_BIT:ERR_FREQ_BIT] : 3'h0;
    // Set wins over clear
    err_d = (err_q & ~err_clr) | err_set;
  end

  always_comb begin
    strobe_term_d = lvl_on && odt;
    dq_term_d = !lvl_on && odt && rtt_nom_on && st_q != ST_PDN;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q <= ST_IDLE;
      mr0_q <= MR_RESET;
      mr1_q <= MR_RESET;
      cnt_q <= 10'h000;
      err_q <= 3'h0;
      dll_locked_q <= 1'b0;
      strobe_term_q <= 1'b0;
      dq_term_q <= 1'b0;
    end else begin
      st_q <= st_d;
      mr0_q <= mr0_d;
      mr1_q <= mr1_d;
      cnt_q <= cnt_d;
      err_q <= err_d;
      dll_locked_q <= dll_locked_d;
      strobe_term_q <= strobe_term_d;
      dq_term_q <= dq_term_d;
    end
  end

  // lower and upper lanes leveled apart
  ddrfl_lane u_lane_lo (
    .aclk(aclk),
    .aresetn(aresetn),
    .lvl_on(lvl_on),
    .strobe(lower_strobe_pair),
    .ck_level(ck_level),
    .dq_q(dq_o[7:0]),
    .dq_oe_q(oe_lo)
  );
  ddrfl_lane u_lane_hi (
    .aclk(aclk),
    .aresetn(aresetn),
    .lvl_on(lvl_on),
    .strobe(upper_strobe_pair),
    .ck_level(ck_level),
    .dq_q(dq_o[15:8]),
    .dq_oe_q(oe_hi)
  );
  // Output enables of a lane switch together, one enable register per lane
  assign dq_oe = {{8{oe_hi}}, {8{oe_lo}}};

  // AXI4-Lite slave next state
  always_comb begin
    aw_have_d = aw_have_q;
    w_have_d = w_have_q;
    awaddr_d = awaddr_q;
    wdata_d = wdata_q;
    wstrb_d = wstrb_q;
    ctrl_d = ctrl_q;
    bvalid_d = s_axi_bvalid;
    bresp_d = s_axi_bresp;
    rvalid_d = s_axi_rvalid;
    rresp_d = s_axi_rresp;
    rdata_d = s_axi_rdata;
    if (s_axi_awvalid && s_axi_awready) begin
      aw_have_d = 1'b1;
      awaddr_d = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_have_d = 1'b1;
      wdata_d = s_axi_wdata;
      wstrb_d = s_axi_wstrb;
    end
    if (wr_go) begin
      aw_have_d = 1'b0;
      w_have_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = RESP_OKAY;
      case (awaddr_q)
        REG_CTRL: begin
          if (wstrb_q[0]) begin
            ctrl_d[CTRL_CHECK_BIT] = wdata_q[CTRL_CHECK_BIT];
          end
        end
        REG_STATUS, REG_MR0, REG_MR1: bresp_d = RESP_OKAY;
        default: bresp_d = RESP_DECERR;
      endcase
    end else if (s_axi_bvalid && s_axi_bready) begin
      bvalid_d = 1'b0;
    end
    awready_d = !aw_have_d && !bvalid_d;
    wready_d = !w_have_d && !bvalid_d;
    if (s_axi_arvalid && s_axi_arready) begin
      rvalid_d = 1'b1;
      rresp_d = RESP_OKAY;
      case (s_axi_araddr)
        REG_CTRL: rdata_d = ctrl_q;
        REG_STATUS: rdata_d = status_w;
        REG_MR0: rdata_d = {16'h0000, mr0_q};
        REG_MR1: rdata_d = {16'h0000, mr1_q};
        default: begin
          rdata_d = 32'h0000_0000;
          rresp_d = RESP_DECERR;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      rvalid_d = 1'b0;
    end
    arready_d = !rvalid_d;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      awaddr_q <= 4'h0;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      ctrl_q <= CTRL_RESET;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= 2'h0;
      s_axi_rdata <= 32'h0000_0000;
    end else begin
      aw_have_q <= aw_have_d;
      w_have_q <= w_have_d;
      awaddr_q <= awaddr_d;
      wdata_q <= wdata_d;
      wstrb_q <= wstrb_d;
      ctrl_q <= ctrl_d;
      s_axi_awready <= awready_d;
      s_axi_wready <= wready_d;
      s_axi_bvalid <= bvalid_d;
      s_axi_bresp <= bresp_d;
      s_axi_arready <= arready_d;
      s_axi_rvalid <= rvalid_d;
      s_axi_rresp <= rresp_d;
      s_axi_rdata <= rdata_d;
    end
  end
endmodule
`default_nettype wire

/* testbench/ddrfl_chk.sv */
// Checker for leveling, termination and relock outputs
`timescale 1ns/1ps
`default_nettype none
module ddrfl_chk
  import ddrfl_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Controller pins
  input wire logic odt,
  input wire logic cmd_valid,
  input wire logic [2:0] cmd_code,
  input wire logic [2:0] cmd_bank,
  input wire logic [15:0] cmd_addr,
  input wire logic ck_level,
  input wire logic lower_strobe_pair,
  input wire logic upper_strobe_pair,
  // Device outputs
  input wire logic [15:0] dq_o,
  input wire logic [15:0] dq_oe,
  input wire logic strobe_term_q,
  input wire logic dq_term_q,
  input wire logic dll_locked_q
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic mr1, rst;
  logic [9:0] cnt_q, cnt_d;
  assign mr1 = cmd_valid && cmd_code == CMD_MRS && cmd_bank == 3'h1;
  assign rst = cmd_valid && cmd_code == CMD_MRS && cmd_bank == 3'h0 && cmd_addr[MR0_DLL_RESET_BIT];
  // Cycles since a DLL reset, saturating
  always_comb begin
    cnt_d = cnt_q;
    if (rst) cnt_d = 10'h1;
    else if (cnt_q != 10'h0 && cnt_q != 10'h3ff) cnt_d = cnt_q + 10'h1;
  end
  // Counter register
  always_ff @(posedge aclk) begin
    if (!aresetn) cnt_q <= 10'h0;
    else cnt_q <= cnt_d;
  end
  lvl_enter_a: assert property (mr1 && cmd_addr[MR1_LVL_BIT]
    |-> ##2 dq_oe == 16'hffff && dq_o == 16'h0) else $error("leveling entry");
  lvl_exit_a: assert property (mr1 && !cmd_addr[MR1_LVL_BIT]
    |-> ##2 dq_oe == 16'h0 && dq_o == 16'h0) else $error("leveling exit");
  low_fb_a: assert property ($rose(lower_strobe_pair) && dq_oe[0]
    |-> ##2 dq_o[7:0] == {8{$past(ck_level, 2)}}) else $error("lower feedback");
  up_fb_a: assert property ($rose(upper_strobe_pair) && dq_oe[8]
    |-> ##2 dq_o[15:8] == {8{$past(ck_level, 2)}}) else $error("upper feedback");
  fb_hold_a: assert property (dq_oe[0] && !lower_strobe_pair ##1 !lower_strobe_pair
    |=> !dq_oe[0] || $stable(dq_o[7:0])) else $error("feedback hold");
  sterm_on_a: assert property (odt && dq_oe[0] |=> strobe_term_q)
    else $error("strobe termination");
  dterm_off_a: assert property (strobe_term_q |-> !dq_term_q)
    else $error("data termination");
  relock_a: assert property (cnt_q != 10'h0 && cnt_q <= TDLLK_NCK |-> !dll_locked_q)
    else $error("early lock");
  locked_a: assert property (cnt_q == TDLLK_NCK + 10'h001 |-> dll_locked_q)
    else $error("late lock");
  cover property (mr1 && cmd_addr[MR1_LVL_BIT]);
  cover property ($rose(upper_strobe_pair) && dq_oe[8]);
  cover property (cnt_q == 10'h212 && dll_locked_q);
endmodule
`default_nettype wire

/* testbench/ddrfl_ctrl_model.sv */
// Memory controller model for command, termination and strobe pins
`timescale 1ns/1ps
`default_nettype none
module ddrfl_ctrl_model
  import ddrfl_pkg::*;
(
  // Clock
  input wire logic aclk,
  // Command and termination pins
  output logic cke,
  output logic odt,
  output logic cmd_valid,
  output logic [2:0] cmd_code,
  output logic [2:0] cmd_bank,
  output logic [15:0] cmd_addr,
  output logic clk_step,
  // Clock level and strobes
  output logic ck_level,
  output logic lower_strobe_pair,
  output logic upper_strobe_pair
);
  // Idle pins at time zero
  initial begin
    {cke, odt, cmd_valid, clk_step, ck_level} = 5'h10;
    {lower_strobe_pair, upper_strobe_pair} = 2'h0;
    {cmd_code, cmd_bank, cmd_addr} = 22'h0;
  end
  // one command, then Deselect with the inverse address on the bus
  task automatic issue(input logic [2:0] c, input logic [2:0] b, input logic [15:0] a);
    @(posedge aclk);
    cmd_valid <= 1'b1;
    {cmd_code, cmd_bank, cmd_addr} <= {c, b, a};
    @(posedge aclk);
    cmd_valid <= 1'b0;
    {cmd_code, cmd_addr} <= {CMD_DES, ~a};
  endtask
  task automatic pins(input logic c, input logic o);
    @(posedge aclk);
    {cke, odt} <= {c, o};
  endtask
  task automatic step();
    @(posedge aclk);
    clk_step <= 1'b1;
    @(posedge aclk);
    clk_step <= 1'b0;
  endtask
  // strobe low, one rising edge, clock level steady around it
  task automatic pulse(input logic up, input logic ck);
    @(posedge aclk);
    ck_level <= ck;
    @(posedge aclk);
    {upper_strobe_pair, lower_strobe_pair} <= {up, !up};
    @(posedge aclk);
    {lower_strobe_pair, upper_strobe_pair} <= 2'h0;
    ck_level <= ~ck;
  endtask
endmodule
`default_nettype wire

/* testbench/ddrfl_test.sv */
// Self-checking bench for clock change and write leveling
`timescale 1ns/1ps
`default_nettype none
module ddrfl_test
  import ddrfl_pkg::*;
;
  logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
  logic [31:0] s_axi_wdata, s_axi_rdata, r;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic cke, odt, cmd_valid, clk_step, ck_level, lower_strobe_pair, upper_strobe_pair;
  logic [2:0] cmd_code, cmd_bank;
  logic [15:0] cmd_addr, dq_o, dq_oe, mr, xq;
  logic strobe_term_q, dq_term_q, dll_locked_q;
  int n_errors = 0, total_checks = 0, cyc = 0, st = 0, lv = 0, lk = 0, er = 0;
  int unsigned seed = 54;
  ddrfl_top DUT (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .cke, .odt, .cmd_valid, .cmd_code, .cmd_bank, .cmd_addr, .clk_step,
    .ck_level, .lower_strobe_pair, .upper_strobe_pair, .dq_o, .dq_oe, .strobe_term_q,
    .dq_term_q, .dll_locked_q);
  ddrfl_ctrl_model ctl (.aclk, .cke, .odt, .cmd_valid, .cmd_code, .cmd_bank, .cmd_addr,
    .clk_step, .ck_level, .lower_strobe_pair, .upper_strobe_pair);
  // 125 MHz clock
  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end
  // Cycle ceiling against hangs
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 4000) begin
      n_errors++;
      complete_run();
    end
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("Error %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Write: address and data offered together, each released when taken
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s);
    logic pa, pw;
    {pa, pw} = 2'h3;
    {s_axi_awaddr, s_axi_wdata, s_axi_wstrb} <= {a, d, s};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    while (pa || pw) begin
      @(posedge aclk);
      pa = pa && !s_axi_awready;
      pw = pw && !s_axi_wready;
      {s_axi_awvalid, s_axi_wvalid} <= {pa, pw};
    end
    while (!s_axi_bvalid) @(posedge aclk);
    s_axi_bready <= 1'b0;
    check(32'(s_axi_bresp), a[1:0] != 2'h0 ? 32'(RESP_DECERR) : 32'(RESP_OKAY));
  endtask
  task automatic axi_rd(input logic [3:0] a, input logic [31:0] exp);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    check(s_axi_rdata, exp);
    check(32'(s_axi_rresp), a[1:0] != 2'h0 ? 32'(RESP_DECERR) : 32'(RESP_OKAY));
  endtask
  // Status word from the bench state
  task automatic st_chk();
    axi_rd(REG_STATUS, 32'(er << 8 | lk << 4 | lv << 3 | st));
  endtask
  task automatic complete_run();
    $display("Checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    aresetn = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wstrb, s_axi_wdata} = 44'h0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    axi_rd(REG_CTRL, CTRL_RESET);
    axi_wr(REG_MR1, 32'hffff, 4'hf);
    axi_rd(REG_MR1, 32'h0);
    // Clock change while idle is flagged
    ctl.step();
    er = 1;
    st_chk();
    axi_wr(REG_STATUS, 32'h701, 4'h1);
    st_chk();
    axi_wr(REG_STATUS, 32'h700, 4'h2);
    er = 0;
    // Clock change in power-down with both pins low
    ctl.pins(1'b0, 1'b0);
    ctl.step();
    st = 1;
    st_chk();
    ctl.pins(1'b1, 1'b0);
    st = 0;
    // DLL reset with termination raised during relock
    ctl.issue(CMD_MRS, 3'h0, 16'h0100);
    ctl.pins(1'b1, 1'b1);
    ctl.pins(1'b1, 1'b0);
    st = 3;
    er = 4;
    st_chk();
    repeat (520) @(posedge aclk);
    st = 0;
    lk = 1;
    st_chk();
    // Self-refresh clock change drops the lock
    ctl.issue(CMD_SRE, 3'h0, 16'h0);
    ctl.step();
    st = 2;
    lk = 0;
    st_chk();
    ctl.issue(CMD_SRX, 3'h0, 16'h0);
    st = 0;
    // random mode value with a permitted termination setting
    r = rnd();
    mr = r[15:0] & 16'hfdbb | 16'h0084;
    ctl.issue(CMD_MRS, 3'h1, mr);
    repeat (2) @(posedge aclk);
    check({dq_oe, dq_o}, 32'hffff_0000);
    lv = 1;
    axi_rd(REG_MR1, 32'(mr));
    ctl.pins(1'b1, 1'b1);
    xq = 16'h0;
    for (int i = 0; i < 16; i++) begin
      r = rnd();
      ctl.pulse(r[0], r[1]);
      xq[{r[0], 3'h0} +: 8] = {8{r[1]}};
      repeat (2) @(posedge aclk);
      check(32'(dq_o), 32'(xq));
      check(32'({dq_term_q, strobe_term_q}), 32'h1);
    end
    ctl.issue(3'h5, 3'h0, 16'h0);
    er = 6;
    st_chk();
    ctl.pins(1'b1, 1'b0);
    ctl.issue(CMD_MRS, 3'h1, mr & 16'hff7f);
    repeat (2) @(posedge aclk);
    check({dq_oe, dq_o}, 32'h0);
    lv = 0;
    axi_wr(REG_STATUS, 32'h700, 4'h2);
    er = 0;
    st_chk();
    // data termination follows ODT outside leveling, off in power-down
    ctl.pins(1'b1, 1'b1);
    repeat (2) @(posedge aclk);
    check(32'({dq_term_q, strobe_term_q}), 32'h2);
    ctl.pins(1'b0, 1'b1);
    ctl.step();
    @(posedge aclk);
    check(32'({dq_term_q, strobe_term_q}), 32'h0);
    st = 1;
    er = 1;
    st_chk();
    // Checks switched off, unmapped offsets refused
    axi_wr(REG_CTRL, 32'h0, 4'h1);
    axi_wr(REG_STATUS, 32'h700, 4'h2);
    axi_wr(4'h2, 32'h1, 4'hf);
    ctl.step();
    er = 0;
    st_chk();
    axi_rd(4'h6, 32'h0);
    axi_rd(REG_CTRL, 32'h0);
    complete_run();
  end
endmodule
bind ddrfl_top ddrfl_chk u_chk (.aclk, .aresetn, .odt, .cmd_valid, .cmd_code, .cmd_bank,
  .cmd_addr, .ck_level, .lower_strobe_pair, .upper_strobe_pair, .dq_o, .dq_oe,
  .strobe_term_q, .dq_term_q, .dll_locked_q);
`default_nettype wire
